//--- tb_top.sv
// Self-checking bench for the vectored interrupt controller
`include "vic_consts.svh"
module tb_top
	import vic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 mclk = 1'b0;
	logic                 rst = 1'b1;
	logic                 wbCyc = 1'b0;
	logic                 wbStb = 1'b0;
	logic                 wbWe = 1'b0;
	logic [3:0]           wbAdr = 4'h0;
	logic [3:0]           wbSel = 4'h0;
	logic [31:0]          wbDatI = 32'h0;
	logic [31:0]          wbDatO;
	logic                 wbAck;
	vic_events_t          events = '0;
	logic                 compOut = 1'b0;
	logic                 slow = 1'b0;
	logic                 sleep = 1'b0;
	logic [1:0]           opCode = 2'h0;
	logic                 opTaken;
	vic_core_req_t        coreReq;
	vic_core_ans_t        coreAns;
	int                   num_errors = 0;
	int                   total_checks = 0;
	int                   cycles = 0; // Run length, cut at the ceiling
	int                   stCnt = 0;  // Strobes since the last event pulse
	int                   jmpCnt = 0; // Jumps seen so far
	logic [7:0]           rd;         // Last read byte
	logic [`VIC_PC_W-1:0] retPc;      // Address the core was interrupted at
	int                   i;
	always #2.5 mclk = ~mclk;
	vic_ctrl u_vic_ctrl (.mclk(mclk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
		.wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
		.events(events), .compOut(compOut), .coreReq(coreReq), .coreAns(coreAns));
	vic_core_model u_vic_core_model (.mclk(mclk), .rst(rst), .slow(slow), .sleep(sleep),
		.opCode(opCode), .coreAns(coreAns), .coreReq(coreReq), .opTaken(opTaken));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Strobe and jump bookkeeping; an event pulse restarts the strobe count
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (events != '0)
			stCnt <= 0;
		else if (coreReq.instrStrobe === 1'b1)
			stCnt <= stCnt + 1;
		if (coreAns.jump === 1'b1)
			jmpCnt <= jmpCnt + 1;
		if (cycles == 20000) begin
			num_errors++;
			close_out();
		end
	end
	// Classic single cycle; held until the answer is sampled
	task automatic wb(input logic [3:0] a, input logic we, input logic [7:0] d);
		int n;
		@(posedge mclk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbSel <= 4'h1;
		wbAdr <= a;
		wbDatI <= {24'h0, d};
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (wbAck !== 1'b1 && n < 64);
		rd = wbDatO[7:0];
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
		wbSel <= 4'h0;
		if (n == 64) chk(0, 1);
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
		wb(a, 1'b0, 8'h00);
		chk(rd, e);
	endtask
	task automatic wait_jump();
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (coreAns.jump !== 1'b1 && n < 400);
		if (n == 400) chk(0, 1);
	endtask
	// Hand one operation to the core and wait until it is issued
	task automatic op(input logic [1:0] c);
		int n;
		@(posedge mclk);
		opCode <= c;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (opTaken !== 1'b1 && n < 64);
		opCode <= 2'h0;
		if (n == 64) chk(0, 1);
	endtask
	task automatic pulse(input logic [7:0] e);
		@(posedge mclk);
		events <= e;
		@(posedge mclk);
		events <= '0;
	endtask
	task automatic cmp(input logic v);
		@(posedge mclk);
		compOut <= v;
		repeat (4) @(posedge mclk);
	endtask
	task automatic rst_do(input int n);
		@(posedge mclk);
		rst <= 1'b1;
		repeat (n) @(posedge mclk);
		rst <= 1'b0;
	endtask
	initial begin
		rst_do(16);
		for (i = 0; i < 4; i++) rdchk({i[1:0], 2'h0}, 8'h00);
		wb(4'h4, 1'b1, 8'hFF);
		wb(4'h8, 1'b1, 8'hFF);
		wb(4'hC, 1'b1, 8'hFF);
		wb(4'h2, 1'b1, 8'hFF);
		wb(4'h0, 1'b1, 8'hFE);
		rdchk(4'h0, 8'h7E);
		rdchk(4'h4, 8'h77);
		rdchk(4'h8, 8'h77);
		rdchk(4'hC, 8'h30);
		rdchk(4'h2, 8'h00);
		chk(jmpCnt, 0);
		// Re-enable inside each service: one vector per service, in priority order
		for (i = 0; i < 6; i++) begin
			rdchk(4'h0, {1'b0, 3'(3'h7 << i), 4'hE});
			wb(4'h0, 1'b1, rd | 8'h01);
			wait_jump();
			chk(coreAns.target, `VIC_VEC_BASE + `VIC_VEC_STEP * i);
			wb(4'h0, 1'b0, 8'h00);
			chk(rd[0], 0);
		end
		rdchk(4'h0, 8'h0E);
		rdchk(4'h4, 8'h07);
		rdchk(4'h8, 8'h77);
		$display("done: registers and priority");
		rst_do(2);
		pulse(8'hFF);
		rdchk(4'h0, 8'h70);
		rdchk(4'h4, 8'h60);
		rdchk(4'h8, 8'h70);
		wb(4'h8, 1'b1, 8'h01);
		pulse(8'h20);
		rdchk(4'h4, 8'h70);
		rdchk(4'h8, 8'h11);
		for (i = 0; i < 4; i++) begin
			wb(4'h4, 1'b1, 8'h00);
			wb(4'hC, 1'b1, {2'h0, i[1:0], 4'h0});
			cmp(1'b1);
			rdchk(4'h4, {2'h0, i[0], 5'h0});
			rdchk(4'hC, {2'h0, i[1:0], 4'h8});
			wb(4'h4, 1'b1, 8'h00);
			cmp(1'b0);
			rdchk(4'h4, {2'h0, i[1], 5'h0});
		end
		$display("done: events");
		rst_do(2);
		wb(4'h0, 1'b1, 8'h03);
		pulse(8'h10);
		wait_jump();
		chk(stCnt, 3);
		retPc = coreReq.pcNow - 14'(stCnt - 1);
		op(2'h3);
		wait_jump();
		chk(coreAns.target, retPc);
		rdchk(4'h0, 8'h03);
		slow <= 1'b1;
		sleep <= 1'b1;
		pulse(8'h10);
		wait_jump();
		chk(stCnt, 4);
		retPc = coreReq.pcNow - 14'(stCnt - 1);
		op(2'h2);
		wait_jump();
		chk(coreAns.target, retPc);
		rdchk(4'h0, 8'h02);
		slow <= 1'b0;
		sleep <= 1'b0;
		$display("done: timing and return");
		rst_do(2);
		for (i = 0; i < 8; i++) op(2'h1);
		@(posedge mclk);
		chk(coreAns.stackFull, 1);
		wb(4'h0, 1'b1, 8'h03);
		pulse(8'h10);
		i = jmpCnt;
		repeat (40) @(posedge mclk);
		chk(jmpCnt - i, 0);
		op(2'h2);
		wait_jump();
		wait_jump();
		chk(coreAns.target, `VIC_VEC_BASE);
		$display("done: full stack");
		close_out();
	end
endmodule

//--- vic_consts.svh
// Constants of the vectored interrupt controller: offsets, bit positions, vectors
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH

`define VIC_PC_W         14
`define VIC_SP_W         4
`define VIC_DEPTH        4'h8
`define VIC_DATA_W       32

// Register byte offsets on the bus
`define VIC_ADR_FIRST    4'h0
`define VIC_ADR_SECOND   4'h4
`define VIC_ADR_MULTI    4'h8
`define VIC_ADR_CONV     4'hC

// Implemented bits; unimplemented bit 7 reads zero in all three, bit 3 also in the pair registers
`define VIC_MASK_FIRST   8'h7F
`define VIC_MASK_PAIR    8'h77
`define VIC_RESET_REG    8'h00

// First control register
`define VIC_B_T1F        6
`define VIC_B_T0F        5
`define VIC_B_EXTF       4
`define VIC_B_T1E        3
`define VIC_B_T0E        2
`define VIC_B_EXTE       1
`define VIC_B_EMI        0
// Second control register and multi-function register share one layout
`define VIC_B_HIF        6
`define VIC_B_MIDF       5
`define VIC_B_LOF        4
`define VIC_B_HIE        2
`define VIC_B_MIDE       1
`define VIC_B_LOE        0
// Converter trigger register
`define VIC_B_MODE_HI    5
`define VIC_B_MODE_LO    4
`define VIC_B_CMP        3

// Comparator edge modes
`define VIC_EDGE_NONE    2'h0
`define VIC_EDGE_RISE    2'h1
`define VIC_EDGE_FALL    2'h2
`define VIC_EDGE_BOTH    2'h3

// Vector of source index n is BASE + STEP * n
`define VIC_VEC_BASE     14'h0004
`define VIC_VEC_STEP     14'h0004
`define VIC_NSRC         6

// Instruction cycles from acknowledge to vector jump
`define VIC_WAIT_RUN     2'h2
`define VIC_WAIT_WAKE    2'h3

`endif

//--- vic_core_model.sv
// Processor core stand-in: strobes, program counter, calls and returns
`include "vic_consts.svh"
module vic_core_model
	import vic_pkg::*;
(
	input  wire logic          mclk,
	input  wire logic          rst,
	input  wire logic          slow,
	input  wire logic          sleep,
	input  wire logic [1:0]    opCode,
	input  wire vic_core_ans_t coreAns,
	output vic_core_req_t      coreReq,
	output logic               opTaken
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0]           phase; // Clocks since the last strobe
	logic [`VIC_PC_W-1:0] pc;    // Address of the next instruction
	logic                 strb;  // Instruction strobe
	logic [1:0]           op;    // Operation carried by the strobe
	// Slow mode spaces strobes four clocks apart instead of two
	always_ff @(posedge mclk) begin
		strb <= 1'b0;
		op <= 2'h0;
		opTaken <= 1'b0;
		phase <= phase + 3'h1;
		if (rst) begin
			phase <= 3'h0;
			pc <= 14'h0100;
		end else if (coreAns.jump) begin
			// A jump replaces the fetch, as a real core would
			pc <= coreAns.target;
		end else if (phase >= (slow ? 3'h3 : 3'h1)) begin
			phase <= 3'h0;
			pc <= pc + 14'h1;
			strb <= 1'b1;
			op <= opCode;
			opTaken <= (opCode != 2'h0);
		end
	end
	// Operation codes: 1 call, 2 plain return, 3 interrupt return
	assign coreReq = '{instrStrobe: strb, sleepWake: sleep, callPush: op == 2'h1,
		retPop: op == 2'h2, retiPop: op == 2'h3, pcNow: pc};
endmodule

//--- vic_ctrl.sv
// Vectored interrupt controller with Wishbone registers and return stack
`include "vic_consts.svh"

module vic_ctrl
	import vic_pkg::*;
(
	input  wire logic                    mclk,
	input  wire logic                    rst,
	// Wishbone classic slave
	input  wire logic                    wbCyc,
	input  wire logic                    wbStb,
	input  wire logic                    wbWe,
	input  wire logic [3:0]              wbAdr,
	input  wire logic [3:0]              wbSel,
	input  wire logic [`VIC_DATA_W-1:0]  wbDatI,
	output logic      [`VIC_DATA_W-1:0]  wbDatO,
	output logic                         wbAck,
	// Peripheral events and comparator level
	input  wire vic_events_t             events,
	input  wire logic                    compOut,
	// Processor core side
	input  wire vic_core_req_t           coreReq,
	output vic_core_ans_t                coreAns
);
	// All registered state of the controller
	// Stack contents live in the memory; only the pointer is reset, so old
	// entries above the pointer are never read back
	typedef struct packed {
		vic_state_t            st;        // Sequencer state
		logic [7:0]            first;     // First control register
		logic [7:0]            second;    // Second control register
		logic [7:0]            multi;     // Multi-function register
		logic [1:0]            edgeMode;  // Comparator edge mode
		logic                  compStat;  // Sampled comparator output
		logic [`VIC_SP_W-1:0]  sp;        // Stack pointer, entries used
		logic [1:0]            waitCnt;   // Strobes left before jump
		logic [`VIC_PC_W-1:0]  vecAddr;   // Latched vector
		logic                  jump;      // Jump pulse to core
		logic [`VIC_PC_W-1:0]  target;    // Jump target to core
		logic                  ack;       // Bus acknowledge
		logic [7:0]            rdat;      // Bus read data
	} vic_ctrl_s_t;

	vic_ctrl_s_t state;       // Current state
	vic_ctrl_s_t next_state;  // Next state

	logic [`VIC_NSRC-1:0]  pend;      // Flag and enable per source
	logic                  anyPend;   // Some source pending
	logic [2:0]            winIdx;    // Winning source index
	logic                  stackFull; // No room to push
	logic                  take;      // Acknowledge this cycle
	logic                  busReq;    // New bus cycle this clock
	logic                  busWr;     // Write strobe on lane 0
	logic                  compEdge;  // Selected comparator edge
	logic                  mfSet;     // Enabled multi sub-source fired
	logic                  stkWr;     // Stack write
	logic [2:0]            stkWrAdr;  // Stack write address
	logic [2:0]            stkRdAdr;  // Stack read address
	logic [`VIC_PC_W-1:0]  stkWrDat;  // Stack write data
	logic [`VIC_PC_W-1:0]  stkRdDat;  // Stack read data

	// Priority among the six request paths
	vic_prio u_prio (
		.pend (pend),
		.any  (anyPend),
		.idx  (winIdx)
	);

	// Return stack storage
	vic_stack_mem u_stack (
		.mclk   (mclk),
		.wrEn   (stkWr),
		.wrAddr (stkWrAdr),
		.wrData (stkWrDat),
		.rdAddr (stkRdAdr),
		.rdData (stkRdDat)
	);

	// Source pending terms, index order is priority order
	always_comb begin
		pend[0] = state.first[`VIC_B_EXTF] & state.first[`VIC_B_EXTE];
		pend[1] = state.first[`VIC_B_T0F] & state.first[`VIC_B_T0E];
		pend[2] = state.first[`VIC_B_T1F] & state.first[`VIC_B_T1E];
		pend[3] = state.second[`VIC_B_LOF] & state.second[`VIC_B_LOE];
		pend[4] = state.second[`VIC_B_MIDF] & state.second[`VIC_B_MIDE];
		pend[5] = state.second[`VIC_B_HIF] & state.second[`VIC_B_HIE];
	end

	// Acknowledge decision; core stack operations take precedence
	// A full stack blocks the acknowledge outright: pushing would overwrite
	// the oldest return address, which is worse than a late service
	always_comb begin
		stackFull = (state.sp == `VIC_DEPTH);
		take = (state.st == VIC_IDLE) && coreReq.instrStrobe
			&& state.first[`VIC_B_EMI]
			&& anyPend
			&& !stackFull
			&& !coreReq.callPush && !coreReq.retPop && !coreReq.retiPop;
	end

	// Bus strobes: one access per cycle, ack follows one clock later
	// The registered ack costs one cycle per access but keeps the decode
	// and read mux off the path from the master's strobe
	always_comb begin
		busReq = wbCyc && wbStb && !state.ack;
		busWr  = busReq && wbWe && wbSel[0];
	end

	// Comparator edge selection for the converter flag
	// Status resets low, matching an idle comparator, so no false edge follows reset
	always_comb begin
		case (state.edgeMode)
			`VIC_EDGE_RISE: compEdge = compOut && !state.compStat;
			`VIC_EDGE_FALL: compEdge = !compOut && state.compStat;
			`VIC_EDGE_BOTH: compEdge = compOut != state.compStat;
			default:        compEdge = 1'b0;
		endcase
	end

	// Multi-function trigger only from sub-sources that are enabled
	always_comb begin
		mfSet = (events.touchWide && state.multi[`VIC_B_HIE])
			|| (events.touchNarrow && state.multi[`VIC_B_MIDE])
			|| (events.t2Ovf && state.multi[`VIC_B_LOE]);
	end

	// Stack port control: push on acknowledge or call, read on return
	// A call is only written while idle; a call that the sequencer ignores
	// must not scribble over the slot that a pending return is reading
	always_comb begin
		stkWr    = (take || (coreReq.callPush && coreReq.instrStrobe
			&& state.st == VIC_IDLE)) && !stackFull;
		stkWrAdr = state.sp[2:0];
		stkWrDat = coreReq.pcNow;
		stkRdAdr = 3'(state.sp - 4'h1);
	end

	// Next-state logic
	// Order below sets priority: writes, then service, then returns, then events
	always_comb begin
		next_state = state;
		next_state.jump = 1'b0;
		next_state.ack = busReq;
		next_state.compStat = compOut;

		// Software writes; flag bits are writable, unimplemented bits dropped
		if (busWr) begin
			case (wbAdr)
				`VIC_ADR_FIRST:  next_state.first = wbDatI[7:0] & `VIC_MASK_FIRST;
				`VIC_ADR_SECOND: next_state.second = wbDatI[7:0] & `VIC_MASK_PAIR;
				`VIC_ADR_MULTI:  next_state.multi = wbDatI[7:0] & `VIC_MASK_PAIR;
				`VIC_ADR_CONV: begin
					// Status bit is read-only and ignores the write
					next_state.edgeMode = wbDatI[`VIC_B_MODE_HI:`VIC_B_MODE_LO];
				end
				default: begin
					// Unmapped: write ignored, still acknowledged
				end
			endcase
		end

		// Acknowledge: clear own flag and master enable, push, latch vector
		if (take) begin
			next_state.first[`VIC_B_EMI] = 1'b0;
			case (winIdx)
				3'h0:    next_state.first[`VIC_B_EXTF] = 1'b0;
				3'h1:    next_state.first[`VIC_B_T0F] = 1'b0;
				3'h2:    next_state.first[`VIC_B_T1F] = 1'b0;
				3'h3:    next_state.second[`VIC_B_LOF] = 1'b0;
				3'h4:    next_state.second[`VIC_B_MIDF] = 1'b0;
				default: next_state.second[`VIC_B_HIF] = 1'b0;
			endcase
			next_state.vecAddr = `VIC_VEC_BASE
				+ `VIC_VEC_STEP * {11'h000, winIdx};
			next_state.sp = state.sp + 4'h1;
			next_state.waitCnt = coreReq.sleepWake ? `VIC_WAIT_WAKE : `VIC_WAIT_RUN;
			next_state.st = VIC_WAIT;
		end

		// Plain subroutine call from the core also uses the stack
		// A call while full is dropped; software must keep one slot for service
		if (coreReq.instrStrobe && coreReq.callPush && !stackFull
			&& state.st == VIC_IDLE) begin
			next_state.sp = state.sp + 4'h1;
		end

		// Returns pop the stack; the read data arrive one clock later
		if (coreReq.instrStrobe && (coreReq.retPop || coreReq.retiPop)
			&& state.st == VIC_IDLE && state.sp != 4'h0) begin
			next_state.sp = state.sp - 4'h1;
			next_state.st = VIC_POP;
			if (coreReq.retiPop) begin
				next_state.first[`VIC_B_EMI] = 1'b1;
			end
		end

		// Sequencer
		// Only one jump can be pending at a time, since WAIT and POP both block
		// new acknowledges and returns until they drop back to IDLE
		case (state.st)
			VIC_IDLE: begin
				// Waiting for a request or a return
			end
			VIC_WAIT: begin
				// Count instruction strobes, then jump to the vector
				if (coreReq.instrStrobe) begin
					next_state.waitCnt = state.waitCnt - 2'h1;
					if (state.waitCnt == 2'h1) begin
						next_state.jump = 1'b1;
						next_state.target = state.vecAddr;
						next_state.st = VIC_IDLE;
					end
				end
			end
			VIC_POP: begin
				// Popped address is now on the read port
				next_state.jump = 1'b1;
				next_state.target = stkRdDat;
				next_state.st = VIC_IDLE;
			end
			default: next_state.st = VIC_IDLE;
		endcase

		// Events set flags last so a set wins over any clear
		// A request that meets a software clear in the same clock is therefore kept
		next_state.first[`VIC_B_EXTF] |= events.extEdge;
		next_state.first[`VIC_B_T0F] |= events.t0Ovf;
		next_state.first[`VIC_B_T1F] |= events.t1Ovf;
		next_state.second[`VIC_B_HIF] |= events.touchDone;
		next_state.second[`VIC_B_MIDF] |= events.convDone | compEdge;
		next_state.second[`VIC_B_LOF] |= mfSet;
		next_state.multi[`VIC_B_HIF] |= events.touchWide;
		next_state.multi[`VIC_B_MIDF] |= events.touchNarrow;
		next_state.multi[`VIC_B_LOF] |= events.t2Ovf;

		// Read data captured with the ack; masks keep reserved bits zero
		// Reads have no side effects, so a repeated read returns the same byte
		if (busReq) begin
			case (wbAdr)
				`VIC_ADR_FIRST:  next_state.rdat = state.first & `VIC_MASK_FIRST;
				`VIC_ADR_SECOND: next_state.rdat = state.second & `VIC_MASK_PAIR;
				`VIC_ADR_MULTI:  next_state.rdat = state.multi & `VIC_MASK_PAIR;
				`VIC_ADR_CONV:   next_state.rdat = {2'h0, state.edgeMode,
					state.compStat, 3'h0};
				default:         next_state.rdat = 8'h00;
			endcase
		end
	end

	// State register, synchronous reset to all-disabled
	// Fields are reset one by one so the reset branch holds constants only
	always_ff @(posedge mclk) begin
		if (rst) begin
			state.st       <= VIC_IDLE;
			state.first    <= `VIC_RESET_REG;
			state.second   <= `VIC_RESET_REG;
			state.multi    <= `VIC_RESET_REG;
			state.edgeMode <= `VIC_EDGE_NONE;
			state.compStat <= 1'b0;
			state.sp       <= 4'h0;
			state.waitCnt  <= 2'h0;
			state.vecAddr  <= 14'h0000;
			state.jump     <= 1'b0;
			state.target   <= 14'h0000;
			state.ack      <= 1'b0;
			state.rdat     <= 8'h00;
		end else begin
			state <= next_state;
		end
	end

	// Outputs
	// stackFull is combinational so the core sees a full stack on the same strobe
	always_comb begin
		wbAck             = state.ack;
		wbDatO            = {24'h000000, state.rdat};
		coreAns.jump      = state.jump;
		coreAns.target    = state.target;
		coreAns.stackFull = stackFull;
	end
endmodule

//--- vic_ctrl_sva.sv
// Concurrent checks on the ports of the interrupt controller
`include "vic_consts.svh"
module vic_ctrl_sva
	import vic_pkg::*;
(
	input wire logic                   mclk,
	input wire logic                   rst,
	input wire logic                   wbCyc,
	input wire logic                   wbStb,
	input wire logic                   wbWe,
	input wire logic [3:0]             wbAdr,
	input wire logic [`VIC_DATA_W-1:0] wbDatO,
	input wire logic                   wbAck,
	input wire vic_core_req_t          coreReq,
	input wire vic_core_ans_t          coreAns
);
	timeunit 1ns;
	timeprecision 1ps;
	// One clock domain, so clock and reset are given once
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (rst);
	// Request still waiting for its answer
	sequence s_req;
		wbCyc && wbStb && !wbAck;
	endsequence
	// Answer lasting exactly one clock
	sequence s_ack;
		wbAck ##1 !wbAck;
	endsequence
	AST_BUS_ACK: assert property (s_req |=> s_ack)
		else $error("bus answer late or too long");
	AST_RST_QUIET: assert property (disable iff (1'b0) rst ##1 rst |=>
		!wbAck && !coreAns.jump && coreAns.target == 14'h0 && !coreAns.stackFull)
		else $error("outputs not quiet after reset");
	AST_READ_HIGH: assert property (wbAck && !$past(wbWe) |-> wbDatO[31:7] == 25'h0
		&& !(wbDatO[3] && ($past(wbAdr) == 4'h4 || $past(wbAdr) == 4'h8)))
		else $error("unimplemented bit read as one");
	AST_UNMAPPED: assert property (wbAck && !$past(wbWe) && $past(wbAdr[1:0]) != 2'h0
		|-> wbDatO == 32'h0)
		else $error("unmapped read not zero");
	AST_TRIG_LAYOUT: assert property (wbAck && !$past(wbWe) && $past(wbAdr) == 4'hC
		|-> wbDatO[7:6] == 2'h0 && wbDatO[2:0] == 3'h0)
		else $error("trigger register spare bits set");
	AST_JUMP_PULSE: assert property (coreAns.jump |=> !coreAns.jump)
		else $error("jump longer than one clock");
	AST_JUMP_CAUSE: assert property (coreAns.jump |-> $past(coreReq.instrStrobe)
		|| $past(coreReq.instrStrobe && (coreReq.retPop || coreReq.retiPop), 2))
		else $error("jump not tied to a strobe");
	AST_TARGET_HOLD: assert property (!$past(rst) && $changed(coreAns.target)
		|-> coreAns.jump)
		else $error("target moved without a jump");
	// Full stack stays full until a return pops it
	AST_FULL_HOLD: assert property (coreAns.stackFull && !(coreReq.instrStrobe
		&& (coreReq.retPop || coreReq.retiPop)) |=> coreAns.stackFull)
		else $error("full stack took a push");
endmodule

bind vic_ctrl vic_ctrl_sva u_vic_ctrl_sva (.mclk(mclk), .rst(rst), .wbCyc(wbCyc),
	.wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbDatO(wbDatO), .wbAck(wbAck),
	.coreReq(coreReq), .coreAns(coreAns));

//--- vic_pkg.sv
// Types shared by the vectored interrupt controller modules
`include "vic_consts.svh"
package vic_pkg;
	// Sequencer states
	typedef enum logic [1:0] {
		VIC_IDLE = 2'b00,
		VIC_WAIT = 2'b01,
		VIC_POP  = 2'b10
	} vic_state_t;

	// One-cycle event pulses from the peripherals
	typedef struct packed {
		logic t0Ovf;
		logic t1Ovf;
		logic t2Ovf;
		logic extEdge;
		logic touchWide;
		logic touchNarrow;
		logic touchDone;
		logic convDone;
	} vic_events_t;

	// Requests from the processor core
	typedef struct packed {
		logic                  instrStrobe;
		logic                  sleepWake;
		logic                  callPush;
		logic                  retPop;
		logic                  retiPop;
		logic [`VIC_PC_W-1:0]  pcNow;
	} vic_core_req_t;

	// Answers to the processor core
	typedef struct packed {
		logic                  jump;
		logic [`VIC_PC_W-1:0]  target;
		logic                  stackFull;
	} vic_core_ans_t;
endpackage

//--- vic_prio.sv
// Fixed-priority selector, lowest index wins
`include "vic_consts.svh"
module vic_prio
	import vic_pkg::*;
(
	input  wire logic [`VIC_NSRC-1:0] pend,
	output logic                      any,
	output logic      [2:0]           idx
);
	// Scan from the top so the lowest pending index is left last
	always_comb begin
		any = |pend;
		idx = 3'h0;
		for (int i = `VIC_NSRC - 1; i >= 0; i--) begin
			if (pend[i]) begin
				idx = 3'(i);
			end
		end
	end
endmodule

//--- vic_stack_mem.sv
// Return stack memory with registered read data
`include "vic_consts.svh"
module vic_stack_mem
	import vic_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  wrEn,
	input  wire logic [2:0]            wrAddr,
	input  wire logic [`VIC_PC_W-1:0]  wrData,
	input  wire logic [2:0]            rdAddr,
	output logic      [`VIC_PC_W-1:0]  rdData
);
	// Storage, contents undefined until pushed
	logic [`VIC_PC_W-1:0] mem [8];

	// Write port and registered read port
	always_ff @(posedge mclk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end
endmodule
